// ---- rtl/dpss_defs.vh ----
`ifndef DPSS_DEFS_VH
`define DPSS_DEFS_VH

// ----------------------------------------
// register byte addresses, per pipe
// ----------------------------------------
`define DPSS_SRC_A_ADDR 20'h6001c
`define DPSS_SRC_B_ADDR 20'h6101c
`define DPSS_SRC_C_ADDR 20'h6201c
`define DPSS_TRIM_A_ADDR 20'h60020
`define DPSS_TRIM_B_ADDR 20'h61020
`define DPSS_TRIM_C_ADDR 20'h62020
`define DPSS_STAT_A_ADDR 20'h70058
`define DPSS_STAT_B_ADDR 20'h71058
`define DPSS_STAT_C_ADDR 20'h72058
`define DPSS_PIPE_STRIDE 20'h01000

// ----------------------------------------
// field positions
// ----------------------------------------
`define DPSS_HI_MSB 28
`define DPSS_HI_LSB 16
`define DPSS_LO_MSB 12
`define DPSS_LO_LSB 0
`define DPSS_ST_UNDERRUN 31
`define DPSS_ST_VBLANK 30
`define DPSS_ST_FRAME 29
`define DPSS_ST_BWCRED 6
`define DPSS_ST_BCRED 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define DPSS_FIELD_RST 13'h0000
`define DPSS_STAT_RST 5'h00

`endif

// ---- rtl/dpss_pipe_slice.v ----
`timescale 1ns/1ps
// one pipe: double-buffered size and trim, sticky status
`include "dpss_defs.vh"
module dpss_pipe_slice (
    sys_clk,
    nrst,
    srcWrHi,
    srcWrLo,
    trimWrHi,
    trimWrLo,
    wrData,
    statWr,
    pipeEnable,
    vgaMode,
    vblankStart,
    frameStart,
    underrun,
    bwCreditsPending,
    bCreditsPending,
    vgaHorizMinus1,
    vgaVertMinus1,
    transHorizActive,
    srcPendHi,
    srcPendLo,
    trimPendHi,
    trimPendLo,
    statusFlags,
    activeHoriz,
    activeVert,
    trimLeft,
    trimRight,
    pipeHorizSize
);
    input wire sys_clk;
    input wire nrst;
    input wire srcWrHi;
    input wire srcWrLo;
    input wire trimWrHi;
    input wire trimWrLo;
    input wire [31:0] wrData;
    input wire statWr;
    input wire pipeEnable;
    input wire vgaMode;
    input wire vblankStart;
    input wire frameStart;
    input wire underrun;
    input wire bwCreditsPending;
    input wire bCreditsPending;
    input wire [12:0] vgaHorizMinus1;
    input wire [12:0] vgaVertMinus1;
    input wire [12:0] transHorizActive;
    output reg [12:0] srcPendHi;
    output reg [12:0] srcPendLo;
    output reg [12:0] trimPendHi;
    output reg [12:0] trimPendLo;
    output wire [4:0] statusFlags;
    output reg [12:0] activeHoriz;
    output reg [12:0] activeVert;
    output reg [12:0] trimLeft;
    output reg [12:0] trimRight;
    output reg [14:0] pipeHorizSize;

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [12:0] srcActHi_r; // armed horizontal minus one
    reg [12:0] srcActLo_r; // armed vertical minus one
    reg [4:0] stat_r; // underrun, vblank, frame, bw, b
    wire [4:0] evt; // event set terms
    wire [4:0] clr; // write-one clear terms

    assign evt = {underrun, vblankStart, frameStart,
                  vblankStart & bwCreditsPending, vblankStart & bCreditsPending};
    assign clr = statWr ? {wrData[`DPSS_ST_UNDERRUN], wrData[`DPSS_ST_VBLANK],
                  wrData[`DPSS_ST_FRAME], wrData[`DPSS_ST_BWCRED],
                  wrData[`DPSS_ST_BCRED]} : 5'h00;
    assign statusFlags = stat_r;

    // ----------------------------------------
    // pending copies written by software
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!nrst) begin
            srcPendHi <= `DPSS_FIELD_RST;
            srcPendLo <= `DPSS_FIELD_RST;
            trimPendHi <= `DPSS_FIELD_RST;
            trimPendLo <= `DPSS_FIELD_RST;
        end else begin
            if (srcWrHi) srcPendHi <= wrData[`DPSS_HI_MSB:`DPSS_HI_LSB];
            if (srcWrLo) srcPendLo <= wrData[`DPSS_LO_MSB:`DPSS_LO_LSB];
            if (trimWrHi) trimPendHi <= wrData[`DPSS_HI_MSB:`DPSS_HI_LSB];
            if (trimWrLo) trimPendLo <= wrData[`DPSS_LO_MSB:`DPSS_LO_LSB];
        end
    end

    // ----------------------------------------
    // active copies, moved at vblank start
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!nrst) begin
            srcActHi_r <= `DPSS_FIELD_RST;
            srcActLo_r <= `DPSS_FIELD_RST;
            trimLeft <= `DPSS_FIELD_RST;
            trimRight <= `DPSS_FIELD_RST;
        end else begin
            // size arms only at vblank start
            if (vblankStart) begin
                srcActHi_r <= srcPendHi;
                srcActLo_r <= srcPendLo;
            end
            // trim also follows at once while pipe is off
            if (vblankStart || !pipeEnable) begin
                trimRight <= trimPendHi;
                trimLeft <= trimPendLo;
            end
        end
    end

    // ----------------------------------------
    // sticky status, set wins over clear
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!nrst) begin
            stat_r <= `DPSS_STAT_RST;
        end else begin
            stat_r <= evt | (stat_r & ~clr);
        end
    end

    // ----------------------------------------
    // effective sizes seen by the pipe
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!nrst) begin
            activeHoriz <= `DPSS_FIELD_RST;
            activeVert <= `DPSS_FIELD_RST;
            pipeHorizSize <= 15'h0000;
        end else begin
            // vga mode overrides the size register
            activeHoriz <= vgaMode ? vgaHorizMinus1 : srcActHi_r;
            activeVert <= vgaMode ? vgaVertMinus1 : srcActLo_r;
            // one-based counts add straight onto active width
            pipeHorizSize <= {2'b00, transHorizActive} + {2'b00, trimLeft}
                + {2'b00, trimRight};
        end
    end
endmodule // dpss_pipe_slice

// ---- rtl/dpss_top.v ----
`timescale 1ns/1ps
`include "dpss_defs.vh"
module dpss_top (
    sys_clk,
    nrst,
    regAddr,
    regWrEn,
    regRdEn,
    regByteEn,
    regWrData,
    regRdData,
    regRdValid,
    pipeEnable,
    vgaMode,
    vblankStart,
    frameStart,
    underrun,
    bwCreditsPending,
    bCreditsPending,
    vgaHorizMinus1,
    vgaVertMinus1,
    transHorizActive,
    srcHorizMinus1,
    srcVertMinus1,
    trimLeftCount,
    trimRightCount,
    pipeHorizSize
);
    input wire sys_clk;
    input wire nrst;
    input wire [19:0] regAddr; // byte address of mmio access
    input wire regWrEn; // one-cycle write strobe
    input wire regRdEn; // one-cycle read strobe
    input wire [3:0] regByteEn; // byte lanes of a write
    input wire [31:0] regWrData;
    output reg [31:0] regRdData;
    output reg regRdValid;
    input wire [2:0] pipeEnable; // per pipe, same clock
    input wire [2:0] vgaMode;
    input wire [2:0] vblankStart; // one-cycle pulses from transcoder
    input wire [2:0] frameStart;
    input wire [2:0] underrun;
    input wire [2:0] bwCreditsPending;
    input wire [2:0] bCreditsPending;
    input wire [38:0] vgaHorizMinus1; // 13 bits per pipe
    input wire [38:0] vgaVertMinus1;
    input wire [38:0] transHorizActive;
    output wire [38:0] srcHorizMinus1;
    output wire [38:0] srcVertMinus1;
    output wire [38:0] trimLeftCount;
    output wire [38:0] trimRightCount;
    output wire [44:0] pipeHorizSize; // 15 bits per pipe

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    reg [2:0] hitSrc; // per pipe source size hit
    reg [2:0] hitTrim; // per pipe trim hit
    reg [2:0] hitStat; // per pipe status hit
    wire hiLanes; // bytes covering bits 28:16
    wire loLanes; // bytes covering bits 12:0
    wire statLanes; // any lane for status clears

    assign hiLanes = regByteEn[2] & regByteEn[3];
    assign loLanes = regByteEn[0] & regByteEn[1];
    assign statLanes = |regByteEn;

    // decode each pipe by its own full address
    always @* begin
        hitSrc[0] = (regAddr == `DPSS_SRC_A_ADDR);
        hitSrc[1] = (regAddr == `DPSS_SRC_B_ADDR);
        hitSrc[2] = (regAddr == `DPSS_SRC_C_ADDR);
        hitTrim[0] = (regAddr == `DPSS_TRIM_A_ADDR);
        hitTrim[1] = (regAddr == `DPSS_TRIM_B_ADDR);
        hitTrim[2] = (regAddr == `DPSS_TRIM_C_ADDR);
        hitStat[0] = (regAddr == `DPSS_STAT_A_ADDR);
        hitStat[1] = (regAddr == `DPSS_STAT_B_ADDR);
        hitStat[2] = (regAddr == `DPSS_STAT_C_ADDR);
    end

    // ----------------------------------------
    // per pipe slices
    // ----------------------------------------
    wire [38:0] srcPendHiAll;
    wire [38:0] srcPendLoAll;
    wire [38:0] trimPendHiAll;
    wire [38:0] trimPendLoAll;
    wire [14:0] statAll; // five flags per pipe

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : gPipe
            dpss_pipe_slice uSlice (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .srcWrHi(regWrEn & hitSrc[gi] & hiLanes),
                .srcWrLo(regWrEn & hitSrc[gi] & loLanes),
                .trimWrHi(regWrEn & hitTrim[gi] & hiLanes),
                .trimWrLo(regWrEn & hitTrim[gi] & loLanes),
                .wrData(regWrData),
                .statWr(regWrEn & hitStat[gi] & statLanes),
                .pipeEnable(pipeEnable[gi]),
                .vgaMode(vgaMode[gi]),
                .vblankStart(vblankStart[gi]),
                .frameStart(frameStart[gi]),
                .underrun(underrun[gi]),
                .bwCreditsPending(bwCreditsPending[gi]),
                .bCreditsPending(bCreditsPending[gi]),
                .vgaHorizMinus1(vgaHorizMinus1[gi*13 +: 13]),
                .vgaVertMinus1(vgaVertMinus1[gi*13 +: 13]),
                .transHorizActive(transHorizActive[gi*13 +: 13]),
                .srcPendHi(srcPendHiAll[gi*13 +: 13]),
                .srcPendLo(srcPendLoAll[gi*13 +: 13]),
                .trimPendHi(trimPendHiAll[gi*13 +: 13]),
                .trimPendLo(trimPendLoAll[gi*13 +: 13]),
                .statusFlags(statAll[gi*5 +: 5]),
                .activeHoriz(srcHorizMinus1[gi*13 +: 13]),
                .activeVert(srcVertMinus1[gi*13 +: 13]),
                .trimLeft(trimLeftCount[gi*13 +: 13]),
                .trimRight(trimRightCount[gi*13 +: 13]),
                .pipeHorizSize(pipeHorizSize[gi*15 +: 15])
            );
        end
    endgenerate

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [31:0] rdMux; // word selected by address
    integer pi;

    // pending values read back; reserved bits zero
    always @* begin
        rdMux = 32'h00000000;
        for (pi = 0; pi < 3; pi = pi + 1) begin
            if (hitSrc[pi]) begin
                rdMux = {3'b000, srcPendHiAll[pi*13 +: 13], 3'b000,
                         srcPendLoAll[pi*13 +: 13]};
            end
            if (hitTrim[pi]) begin
                rdMux = {3'b000, trimPendHiAll[pi*13 +: 13], 3'b000,
                         trimPendLoAll[pi*13 +: 13]};
            end
            if (hitStat[pi]) begin
                rdMux = {statAll[pi*5+4], statAll[pi*5+3], statAll[pi*5+2],
                         22'h000000, statAll[pi*5+1], statAll[pi*5], 5'h00};
            end
        end
    end

    // ----------------------------------------
    // registered read answer, one cycle later
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!nrst) begin
            regRdData <= 32'h00000000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            // unmapped reads return zero
            if (regRdEn) regRdData <= rdMux;
        end
    end
endmodule // dpss_top

// ---- dv/dpss_top_monitor.sv ----
`timescale 1ns/1ps
`include "dpss_defs.vh"
module dpss_top_monitor (
    input wire logic sys_clk, nrst, regRdEn, regRdValid,
    input wire logic [19:0] regAddr,
    input wire logic [31:0] regRdData,
    input wire logic [2:0] vgaMode, vblankStart,
    input wire logic [38:0] vgaVertMinus1, transHorizActive, srcVertMinus1,
    input wire logic [38:0] trimLeftCount, trimRightCount,
    input wire logic [44:0] pipeHorizSize
);
    // ----------------------------------------
    // read handshake, sizes and flags of pipe a
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_rd_valid: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    a_valid_pulse: assert property (!regRdEn |=> !regRdValid)
        else $error("stray read valid");
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved");
    a_unmapped_zero: assert property (regRdEn && regAddr == 20'h70000 |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_resv_zero: assert property (regRdValid |-> regRdData[15:13] == 3'h0)
        else $error("reserved bits set");
    a_vga_override: assert property (
        (vgaMode[0] && $stable(vgaVertMinus1[12:0]))[*3] |-> srcVertMinus1[12:0] == vgaVertMinus1[12:0])
        else $error("vga size not used");
    a_size_vblank: assert property (
        $changed(srcVertMinus1[12:0]) && $past(nrst) && $past(nrst, 2) && !vgaMode[0]
        && !$past(vgaMode[0]) && !$past(vgaMode[0], 2) |-> $past(vblankStart[0], 2))
        else $error("size moved outside vblank");
    a_width_sum: assert property ($past(nrst) |-> pipeHorizSize[14:0] ==
        {2'b00, $past(transHorizActive[12:0])} + $past(trimLeftCount[12:0])
        + $past(trimRightCount[12:0]))
        else $error("pipe width wrong");
    a_vblank_flag: assert property (
        vblankStart[0] ##1 (regRdEn && regAddr == `DPSS_STAT_A_ADDR) |=> regRdData[30])
        else $error("vblank flag missing");
    c_vblank: cover property (vblankStart[0]);
    c_vga: cover property (vgaMode[0] [*3]);
    c_underrun: cover property (regRdValid && regRdData[31]);
endmodule // dpss_top_monitor

bind dpss_top dpss_top_monitor i_mon (.sys_clk, .nrst, .regRdEn, .regRdValid, .regAddr,
    .regRdData, .vgaMode, .vblankStart, .vgaVertMinus1, .transHorizActive, .srcVertMinus1,
    .trimLeftCount, .trimRightCount, .pipeHorizSize);

// ---- dv/dpss_tgen_model.sv ----
`timescale 1ns/1ps
module dpss_tgen_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] vbReq, urReq, bwPend, bPend,
    output logic [2:0] vblankStart, frameStart, underrun,
    output logic [2:0] bwCreditsPending, bCreditsPending
);
    // ----------------------------------------
    // transcoder events, launched on request
    // ----------------------------------------
    logic [2:0] fsDly_r; // frame start trails vblank
    always @(posedge sys_clk) begin
        if (!nrst) begin
            {vblankStart, frameStart, underrun, fsDly_r} <= 12'h000;
        end else begin
            vblankStart <= vbReq;
            fsDly_r <= vbReq;
            frameStart <= fsDly_r;
            underrun <= urReq;
        end
    end
    // credit levels only hold true at vblank, inverted otherwise
    always @(posedge sys_clk) begin
        bwCreditsPending <= (vbReq != 3'h0) ? bwPend : ~bwPend;
        bCreditsPending <= (vbReq != 3'h0) ? bPend : ~bPend;
    end
endmodule // dpss_tgen_model

// ---- dv/dpss_top_tb.sv ----
`timescale 1ns/1ps
`include "dpss_defs.vh"
module dpss_top_tb;
    logic sys_clk, nrst, regWrEn, regRdEn, regRdValid;
    logic [19:0] regAddr;
    logic [3:0] regByteEn;
    logic [31:0] regWrData, regRdData, e, sz[3];
    logic [2:0] pipeEnable, vgaMode, vbReq, urReq, bwPend, bPend, vbs, fst, ur, bwc, bc;
    logic [38:0] vgaH, vgaV, trans, sH, sV, tL, tR, hExp, vExp;
    logic [44:0] pSize;
    logic [31:0] expQ[$];
    int bad_count, n_checks, cycles, p;
    dpss_tgen_model i_tgen (.sys_clk, .nrst, .vbReq, .urReq, .bwPend, .bPend,
        .vblankStart(vbs), .frameStart(fst), .underrun(ur), .bwCreditsPending(bwc),
        .bCreditsPending(bc));
    dpss_top i_dut (.sys_clk, .nrst, .regAddr, .regWrEn, .regRdEn, .regByteEn, .regWrData,
        .regRdData, .regRdValid, .pipeEnable, .vgaMode, .vblankStart(vbs), .frameStart(fst),
        .underrun(ur), .bwCreditsPending(bwc), .bCreditsPending(bc), .vgaHorizMinus1(vgaH),
        .vgaVertMinus1(vgaV), .transHorizActive(trans), .srcHorizMinus1(sH),
        .srcVertMinus1(sV), .trimLeftCount(tL), .trimRightCount(tR), .pipeHorizSize(pSize));
    // ----------------------------------------
    // clock, checks, bus tasks
    // ----------------------------------------
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [44:0] ex, input logic [44:0] got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        regWrEn = 1; regAddr = a; regWrData = d;
        cyc(1);
        regWrEn = 0;
        cyc(1);
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] ex);
        regRdEn = 1; regAddr = a; expQ.push_back(ex);
        cyc(1);
        regRdEn = 0;
        cyc(1);
    endtask
    task automatic ev(input logic [2:0] m); // vblank request, frame start follows
        vbReq = m;
        cyc(1);
        vbReq = 0;
        cyc(4);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read data scored against the oldest note
    always @(posedge sys_clk) begin
        if (nrst && regRdValid === 1'b1) chk("rdata", expQ.pop_front(), regRdData);
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {nrst, regWrEn, regRdEn, vbReq, urReq, bwPend, bPend, vgaMode} = 0;
        regAddr = 0; regByteEn = 4'hf; regWrData = 0; pipeEnable = 3'h7;
        void'($urandom(32'h0955));
        vgaH = {$urandom, $urandom}; vgaV = {$urandom, $urandom};
        trans = 0;
        hExp = 0; vExp = 0;
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1;
        rd(`DPSS_SRC_A_ADDR, 0); rd(`DPSS_STAT_A_ADDR, 0); rd(20'h70000, 0);
        $display("test reset done");
        for (p = 0; p < 3; p++) begin
            e = $urandom;
            sz[p] = {3'h0, e[27:17], 2'h1, 3'h0, e[12:1], 1'b1};
            trans[13*p+:13] = sz[p][28:16] + 13'h1;
            wr(`DPSS_SRC_A_ADDR + p * `DPSS_PIPE_STRIDE, sz[p]);
        end
        for (p = 0; p < 3; p++) rd(`DPSS_SRC_A_ADDR + p * `DPSS_PIPE_STRIDE, sz[p]);
        cyc(3);
        chk("held", 0, sH);
        for (p = 0; p < 3; p++) begin
            ev(3'h1 << p);
            hExp[13*p+:13] = sz[p][28:16];
            vExp[13*p+:13] = sz[p][12:0];
            chk("horiz", hExp, sH);
            chk("vert", vExp, sV);
        end
        $display("test size done");
        wr(`DPSS_TRIM_A_ADDR, 32'h00030001);
        cyc(3);
        chk("trim held", 0, tL);
        ev(3'h1);
        chk("left", 1, tL);
        chk("right", 3, tR);
        chk("width", trans[12:0] + 4, pSize[14:0]);
        pipeEnable = 3'h6;
        wr(`DPSS_TRIM_A_ADDR, 32'h00000005);
        cyc(3);
        chk("off left", 5, tL);
        chk("off width", trans[12:0] + 5, pSize[14:0]);
        pipeEnable = 3'h7;
        // only the low lanes: the right count must not move
        regByteEn = 4'h3;
        wr(`DPSS_TRIM_B_ADDR, 32'h00070009);
        regByteEn = 4'hf;
        rd(`DPSS_TRIM_B_ADDR, 32'h00000009);
        $display("test trim done");
        vgaMode = 3'h3;
        cyc(4);
        chk("vga vert", {vExp[38:26], vgaV[25:0]}, sV);
        chk("vga horiz", {hExp[38:26], vgaH[25:0]}, sH);
        vgaMode = 0;
        $display("test vga done");
        for (p = 0; p < 3; p++) wr(`DPSS_STAT_A_ADDR + p * `DPSS_PIPE_STRIDE, 32'hffffffff);
        bwPend = 3'h5; bPend = 3'h3;
        for (p = 0; p < 3; p++) begin
            regAddr = `DPSS_STAT_A_ADDR + p * `DPSS_PIPE_STRIDE;
            e = 32'he0000000 | (32'(bwPend[p]) << 6) | (32'(bPend[p]) << 5);
            // one-cycle vblank and underrun, read right behind the vblank pulse
            urReq = 3'h1 << p;
            vbReq = 3'h1 << p;
            cyc(1);
            {urReq, vbReq} = 0;
            cyc(1);
            rd(regAddr, e & 32'hdfffffff);
            rd(regAddr, e);
            wr(regAddr, 0);
            rd(regAddr, e);
            wr(regAddr, 32'h80000000);
            rd(regAddr, e & 32'h7fffffff);
            // underrun lands in the same cycle as a full clear
            urReq = 3'h1 << p;
            cyc(1);
            urReq = 0;
            wr(regAddr, 32'hffffffff);
            rd(regAddr, 32'h80000000);
            wr(regAddr, 32'hffffffff);
            rd(regAddr, 0);
        end
        $display("test status done");
        cyc(4);
        wrap_up();
    end
endmodule // dpss_top_tb
